// ==== led_pkg.sv ====
// Purpose : constants for the fieldbus status indicator and process data block
// Assumes : 10 MHz clock, asynchronous active-low reset
// Notes   : no software registers; every control is a port
//
// Notes on behaviour
// - status indicator dark while module unpowered, initializing or inactive
// - basic ethernet state: fast green flash, 50 ms on, 50 ms off
// - one, two, three green flashes for preop first, preop second, ready
// - operational state: steady green, process data sent and received
// - stopped state: slow green flash, 200 ms on, 200 ms off
// - outside operational, sent data flagged invalid, received data ignored
// - error dark without error, red for non-fatal, both red when fatal
// - per port link indicator: off, steady with link, flashing with traffic
// - two ports, 100 Mbit half duplex, line or star wiring
// - two 32-bit words each way per cycle
// - weight sent as floating point or integer per configuration
// - second variant: error with run off lights error and enters exception
// - second variant: run green normally, both red on fatal event
package led_pkg;
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned TICK_US       = 1000;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned FAST_MS       = 50;
	localparam int unsigned SLOW_MS       = 200;
	localparam int unsigned FLASH_ON_MS   = 200;
	localparam int unsigned FLASH_GAP_MS  = 200;
	localparam int unsigned FLASH_END_MS  = 2000;
	localparam int unsigned ACT_MS        = 50;
	localparam int unsigned MS_W          = 11;
	localparam int unsigned DW            = 32;
	localparam logic [2:0]  NMT_OFF       = 3'h0;
	localparam logic [2:0]  NMT_BASIC     = 3'h1;
	localparam logic [2:0]  NMT_PREOP1    = 3'h2;
	localparam logic [2:0]  NMT_PREOP2    = 3'h3;
	localparam logic [2:0]  NMT_READY     = 3'h4;
	localparam logic [2:0]  NMT_OPER      = 3'h5;
	localparam logic [2:0]  NMT_STOP      = 3'h6;
	localparam logic [1:0]  LED_OFF       = 2'h0;
	localparam logic [1:0]  LED_GREEN     = 2'h1;
	localparam logic [1:0]  LED_RED       = 2'h2;
	localparam logic [1:0]  LINK_OFF      = 2'h0;
	localparam logic [1:0]  LINK_ON       = 2'h1;
	localparam logic [1:0]  LINK_ACT      = 2'h2;
	localparam int unsigned PORTS         = 2;
	localparam int unsigned PORT_MBIT     = 100;
endpackage

// ==== link_led.sv ====
`timescale 1ns/100ps
// Purpose : one port link/activity indicator
// Assumes : link and activity already synchronised
// Notes   : activity is stretched so short bursts stay visible
module link_led
	import led_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ms_tick,
	input  wire logic link,
	input  wire logic act,
	output logic      led_ff
);
	logic [MS_W-1:0] hold_ff;
	logic [MS_W-1:0] phase_ff;
	wire             busy     = (hold_ff != '0);
	wire             blink    = (phase_ff < MS_W'(ACT_MS));
	wire             nxt_led  = link & (busy ? blink : 1'b1);
	wire [MS_W-1:0]  nxt_hold = act ? MS_W'(2 * ACT_MS) :
	                            (busy & ms_tick) ? hold_ff - 1'b1 : hold_ff;
	wire [MS_W-1:0]  nxt_ph   = !busy ? '0 :
	                            !ms_tick ? phase_ff :
	                            (phase_ff == MS_W'(2 * ACT_MS - 1)) ? '0 : phase_ff + 1'b1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_ff  <= '0;
			phase_ff <= '0;
			led_ff   <= 1'b0;
		end else begin
			hold_ff  <= nxt_hold;
			phase_ff <= nxt_ph;
			led_ff   <= nxt_led;
		end
	end
endmodule // link_led

// ==== status_led_top.sv ====
`timescale 1ns/100ps
// Purpose : status, error and link indicators plus cyclic data exchange
// Assumes : protocol stack drives state, error and data on this clock
// Notes   : link pins come from the phy and are synchronised here
module status_led_top
	import led_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          variant_b,
	input  wire logic [2:0]    nmt_state,
	input  wire logic          module_active,
	input  wire logic          nonfatal_err,
	input  wire logic          fatal_evt,
	input  wire logic          float_fmt,
	input  wire logic [DW-1:0] weight_int,
	input  wire logic [DW-1:0] weight_float,
	input  wire logic [DW-1:0] status_word,
	input  wire logic          cycle_strobe,
	input  wire logic [DW-1:0] rx_word0,
	input  wire logic [DW-1:0] rx_word1,
	input  wire logic          first_port_link,
	input  wire logic          first_port_act,
	input  wire logic          second_port_link,
	input  wire logic          second_port_act,
	output logic [1:0]         network_run_indicator,
	output logic               app_error_indicator,
	output logic               first_port_led,
	output logic               second_port_led,
	output logic [DW-1:0]      tx_word0,
	output logic [DW-1:0]      tx_word1,
	output logic               tx_valid,
	output logic [DW-1:0]      cmd_word0,
	output logic [DW-1:0]      cmd_word1,
	output logic               cmd_update,
	output logic               exception_state
);
	// ==========================================================
	// millisecond time base
	logic [13:0]     div_ff;
	logic            tick_ff;
	logic [MS_W-1:0] ms_ff;
	logic [2:0]      shown_ff;
	wire             div_end = (div_ff == 14'(TICK_CYC - 1));
	wire [13:0]      nxt_div = div_end ? '0 : div_ff + 1'b1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			div_ff  <= nxt_div;
			tick_ff <= div_end;
		end
	end

	// ==========================================================
	// pin synchronisers
	// link pins are asynchronous, so only the second stage is ever decoded
	logic [3:0] s1_ff;
	logic [3:0] s2_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= '0;
			s2_ff <= '0;
		end else begin
			s1_ff <= {second_port_act, second_port_link, first_port_act, first_port_link};
			s2_ff <= s1_ff;
		end
	end

	// ==========================================================
	// pattern generator
	// dark when inactive
	wire [2:0] eff_state = module_active ? nmt_state : NMT_OFF;
	// one stale pattern cycle after a change, far below what the eye sees
	// restart on change
	wire       restart   = (eff_state != shown_ff);

	function automatic logic [MS_W-1:0] period_of(input logic [2:0] st);
		case (st)
			NMT_BASIC: period_of = MS_W'(2 * FAST_MS);
			NMT_STOP:  period_of = MS_W'(2 * SLOW_MS);
			default:   period_of = MS_W'(FLASH_END_MS);
		endcase
	endfunction

	function automatic logic is_oper(input logic active, input logic [2:0] st);
		is_oper = active & (st == NMT_OPER);
	endfunction

	// n flashes of FLASH_ON_MS separated by FLASH_GAP_MS, then dark to period end
	// the loop caps the count at three; the period would hold up to five
	function automatic logic burst(input logic [MS_W-1:0] t, input int unsigned n);
		logic [MS_W-1:0] slot;
		slot  = MS_W'(FLASH_ON_MS + FLASH_GAP_MS);
		burst = 1'b0;
		for (int unsigned i = 0; i < 3; i++) begin
			if (i < n && t >= MS_W'(i) * slot && t < MS_W'(i) * slot + MS_W'(FLASH_ON_MS))
				burst = 1'b1;
		end
	endfunction

	wire [MS_W-1:0] per     = period_of(eff_state);
	wire            ms_wrap = tick_ff && (ms_ff == per - 1'b1);
	wire [MS_W-1:0] nxt_ms  = restart ? '0 :
	                          ms_wrap ? '0 :
	                          tick_ff ? ms_ff + 1'b1 : ms_ff;

	logic green;
	always_comb begin
		green = 1'b0;
		case (eff_state)
			NMT_BASIC:  green = (ms_ff < MS_W'(FAST_MS));
			NMT_PREOP1: green = burst(ms_ff, 1);
			NMT_PREOP2: green = burst(ms_ff, 2);
			NMT_READY:  green = burst(ms_ff, 3);
			NMT_OPER:   green = 1'b1;
			NMT_STOP:   green = (ms_ff < MS_W'(SLOW_MS));
			default:    green = 1'b0;
		endcase
	end

	// run green normal, red on fatal
	wire       run_ok  = variant_b ? is_oper(module_active, nmt_state) : green;
	// fatal outranks the pattern so the red pair is never masked
	// fatal forces both red
	wire [1:0] nxt_run = fatal_evt ? LED_RED : (variant_b ? (run_ok ? LED_GREEN : LED_OFF)
	                                                        : (green ? LED_GREEN : LED_OFF));
	wire       nxt_err = fatal_evt | nonfatal_err;
	wire       nxt_exc = variant_b & nonfatal_err & ~fatal_evt & ~run_ok;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_ff    <= '0;
			shown_ff <= NMT_OFF;
		end else begin
			ms_ff    <= nxt_ms;
			shown_ff <= eff_state;
		end
	end

	// ==========================================================
	// status and error outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			network_run_indicator <= LED_OFF;
			app_error_indicator   <= 1'b0;
			exception_state       <= 1'b0;
		end else begin
			network_run_indicator <= nxt_run;
			app_error_indicator   <= nxt_err;
			exception_state       <= nxt_exc;
		end
	end

	// ==========================================================
	// link indicators
	// two independent ports
	link_led u_first (
		.clk     (clk),
		.rst_n   (rst_n),
		.ms_tick (tick_ff),
		.link    (s2_ff[0]),
		.act     (s2_ff[1]),
		.led_ff  (first_port_led)
	);
	link_led u_second (
		.clk     (clk),
		.rst_n   (rst_n),
		.ms_tick (tick_ff),
		.link    (s2_ff[2]),
		.act     (s2_ff[3]),
		.led_ff  (second_port_led)
	);

	// ==========================================================
	// cyclic process data
	wire          oper     = is_oper(module_active, nmt_state) & ~fatal_evt;
	wire [DW-1:0] weight   = float_fmt ? weight_float : weight_int;
	// words follow every strobe; only tx_valid tells the master to trust them
	// invalid outside operational
	wire          nxt_txv  = oper;
	wire          take_rx  = cycle_strobe & oper;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_word0 <= '0;
			tx_word1 <= '0;
			tx_valid <= 1'b0;
		end else begin
			if (cycle_strobe) begin
				tx_word0 <= weight;
				tx_word1 <= status_word;
			end
			tx_valid <= nxt_txv;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_word0  <= '0;
			cmd_word1  <= '0;
			cmd_update <= 1'b0;
		end else begin
			cmd_update <= take_rx;
			if (take_rx) begin
				cmd_word0 <= rx_word0;
				cmd_word1 <= rx_word1;
			end
		end
	end
endmodule // status_led_top

// ==== status_led_checker.sv ====
`timescale 1ns/100ps
// Purpose: port checker for status_led_top
// Assumes: led_pkg encodings
// Notes: flash phases are too long to see toggle here
module status_led_checker
	import led_pkg::*;
(
	input wire logic          clk,
	input wire logic          rst_n,
	input wire logic          variant_b,
	input wire logic [2:0]    nmt_state,
	input wire logic          module_active,
	input wire logic          nonfatal_err,
	input wire logic          fatal_evt,
	input wire logic          float_fmt,
	input wire logic [DW-1:0] weight_float,
	input wire logic          cycle_strobe,
	input wire logic [DW-1:0] rx_word0,
	input wire logic          first_port_link,
	input wire logic [1:0]    network_run_indicator,
	input wire logic          app_error_indicator,
	input wire logic          first_port_led,
	input wire logic [DW-1:0] tx_word0,
	input wire logic          tx_valid,
	input wire logic [DW-1:0] cmd_word0,
	input wire logic          cmd_update,
	input wire logic          exception_state
);
	// ==== checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic oper = nmt_state == NMT_OPER;
	wire logic live = module_active && oper && !fatal_evt;
	chk_dark_off: assert property (
		!module_active && !fatal_evt |=> network_run_indicator == LED_OFF) else $error("run lit");
	chk_oper_green: assert property (
		(module_active && oper && !fatal_evt)[*2] |=> network_run_indicator == LED_GREEN)
		else $error("run not green");
	chk_fatal_both: assert property (
		fatal_evt |=> network_run_indicator == LED_RED && app_error_indicator) else $error("no red");
	chk_err_clear: assert property (
		!nonfatal_err && !fatal_evt |=> !app_error_indicator) else $error("err lit");
	chk_nonfatal_red: assert property (
		nonfatal_err && !fatal_evt |=> app_error_indicator && network_run_indicator != LED_RED)
		else $error("nonfatal wrong");
	chk_tx_invalid: assert property (
		!live |=> !tx_valid) else $error("tx valid");
	chk_cmd_refused: assert property (
		cycle_strobe && !live |=> !cmd_update) else $error("cmd taken");
	chk_cmd_load: assert property (
		cycle_strobe && live |=> cmd_update && cmd_word0 == $past(rx_word0)) else $error("cmd load");
	chk_tx_float: assert property (
		cycle_strobe && float_fmt |=> tx_word0 == $past(weight_float)) else $error("tx format");
	chk_link_dark: assert property (
		!first_port_link[*5] |-> !first_port_led) else $error("port led lit");
	chk_exc_enter: assert property (
		(variant_b && nonfatal_err && !fatal_evt && !module_active)[*2] |=> exception_state)
		else $error("no exception");
	cov_fatal: cover property (fatal_evt ##1 network_run_indicator == LED_RED);
	cov_cmd: cover property (cycle_strobe && oper ##1 cmd_update);
	cov_exc: cover property (exception_state);
endmodule // status_led_checker

bind status_led_top status_led_checker i_chk (.*);

// ==== plc_master_model.sv ====
`timescale 1ns/100ps
// Purpose: master side of the cyclic exchange
// Assumes: one strobe pulse per exchange cycle
// Notes: rx words change every clock so stale sampling shows
module plc_master_model
	import led_pkg::*;
#(
	parameter int GAP = 20
)
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          run_en,
	input  wire logic          tx_valid,
	input  wire logic [DW-1:0] tx_word0,
	output logic               cycle_strobe,
	output logic [DW-1:0]      rx_word0,
	output logic [DW-1:0]      rx_word1,
	output logic [DW-1:0]      sent_ff,
	output logic [DW-1:0]      sent1_ff,
	output logic [DW-1:0]      seen_ff
);
	int cnt;
	// ==== exchange
	// two words out, only tx_word0 read back
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			cycle_strobe <= 1'b0;
			rx_word0 <= 32'h1357_9BDF;
			rx_word1 <= 32'h0;
			sent_ff <= 32'h0;
			sent1_ff <= 32'h0;
			seen_ff <= 32'h0;
		end else begin
			cnt <= (cnt == GAP) ? 0 : cnt + 1;
			cycle_strobe <= run_en && cnt == GAP;
			rx_word0 <= rx_word0 + 32'h0101_0101;
			rx_word1 <= ~rx_word1;
			if (run_en && cnt == GAP) begin
				sent_ff  <= rx_word0 + 32'h0101_0101;
				sent1_ff <= ~rx_word1;
			end
			if (tx_valid)
				seen_ff <= tx_word0;
		end
	end
endmodule // plc_master_model

// ==== tb_status_led_top.sv ====
`timescale 1ns/100ps
// Purpose: self-checking bench for status_led_top
// Assumes: partner model makes the exchange strobes
// Notes: only the first flash phase fits in the run
module tb_status_led_top
	import led_pkg::*;
;
	logic clk, rst_n, variant_b, module_active, nonfatal_err, fatal_evt, float_fmt, run_en;
	logic [2:0] nmt_state;
	logic [DW-1:0] weight_int, weight_float, status_word, rx_word0, rx_word1, tx_word0, tx_word1;
	logic [DW-1:0] cmd_word0, cmd_word1, sent_ff, sent1_ff, seen_ff;
	logic cycle_strobe, first_port_link, first_port_act, second_port_link, second_port_act;
	logic [1:0] network_run_indicator;
	logic app_error_indicator, first_port_led, second_port_led, tx_valid, cmd_update;
	logic exception_state;
	int fails, num_checks;
	status_led_top i_dut (.*);
	plc_master_model #(.GAP(20)) i_plc (.*);
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// ==== helpers
	task automatic chk(string name, logic [DW-1:0] exp, logic [DW-1:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: exp %h got %h", name, exp, got);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#10;
	endtask
	task automatic stop_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==== scenarios
	task automatic t_states();
		module_active = 1;
		for (int s = 0; s < 8; s++) begin
			nmt_state = s[2:0];
			step(3);
			chk("run", (s == 0 || s == 7) ? LED_OFF : LED_GREEN, network_run_indicator);
			chk("txv", s == NMT_OPER, tx_valid);
		end
		nmt_state = NMT_OPER;
		module_active = 0;
		step(2);
		chk("dark", LED_OFF, network_run_indicator);
		module_active = 1;
	endtask
	task automatic t_errors();
		nonfatal_err = 1;
		step(3);
		chk("run", LED_GREEN, network_run_indicator);
		chk("err", 1, app_error_indicator);
		fatal_evt = 1;
		step(2);
		chk("run", LED_RED, network_run_indicator);
		chk("err", 1, app_error_indicator);
		chk("txv", 0, tx_valid);
		fatal_evt = 0;
		nonfatal_err = 0;
		step(3);
		chk("err", 0, app_error_indicator);
	endtask
	task automatic t_variant();
		variant_b = 1;
		module_active = 0;
		nonfatal_err = 1;
		step(3);
		chk("exc", 1, exception_state);
		nonfatal_err = 0;
		module_active = 1;
		step(3);
		chk("run", LED_GREEN, network_run_indicator);
		chk("exc", 0, exception_state);
		nmt_state = NMT_BASIC;
		nonfatal_err = 1;
		step(3);
		chk("run", LED_OFF, network_run_indicator);
		chk("exc", 1, exception_state);
		fatal_evt = 1;
		step(2);
		chk("run", LED_RED, network_run_indicator);
		chk("err", 1, app_error_indicator);
		chk("exc", 0, exception_state);
		{fatal_evt, nonfatal_err} = 0;
		nmt_state = NMT_OPER;
		step(2);
		variant_b = 0;
	endtask
	task automatic t_data();
		int k;
		run_en = 1;
		for (int f = 0; f < 2; f++) begin
			float_fmt = f[0];
			step(25);
			k = 0;
			while (cmd_update !== 1'b1 && k < 50) begin
				step(1);
				k++;
			end
			chk("cmd_update", 1, cmd_update);
			chk("cmd", sent_ff, cmd_word0);
			chk("cmd1", sent1_ff, cmd_word1);
			chk("tx0", f ? weight_float : weight_int, tx_word0);
			chk("tx1", status_word, tx_word1);
			step(1);
			chk("cmd_update", 0, cmd_update);
		end
		nmt_state = NMT_STOP;
		weight_float = 32'h4000_0000;
		repeat (45) begin
			step(1);
			chk("upd", 0, cmd_update);
		end
		chk("seen", 32'h4148_0000, seen_ff);
		run_en = 0;
	endtask
	task automatic t_links();
		first_port_link = 1;
		second_port_link = 1;
		step(4);
		chk("first_led", 1, first_port_led);
		chk("second_led", 1, second_port_led);
		first_port_act = 1;
		second_port_act = 1;
		step(5);
		chk("first_led", 1, first_port_led);
		chk("second_led", 1, second_port_led);
		first_port_link = 0;
		second_port_link = 0;
		step(5);
		chk("first_led", 0, first_port_led);
		chk("second_led", 0, second_port_led);
	endtask
	task automatic t_reset();
		nmt_state = NMT_OPER;
		step(3);
		chk("run", LED_GREEN, network_run_indicator);
		rst_n = 0;
		step(1);
		chk("run", LED_OFF, network_run_indicator);
		chk("txv", 0, tx_valid);
		chk("err", 0, app_error_indicator);
		rst_n = 1;
		step(2);
		chk("run", LED_GREEN, network_run_indicator);
		chk("txv", 1, tx_valid);
	endtask
	initial begin
		{rst_n, variant_b, module_active, nonfatal_err, fatal_evt, float_fmt, run_en} = 0;
		{first_port_link, first_port_act, second_port_link, second_port_act} = 0;
		nmt_state = NMT_OFF;
		weight_int = 32'h0000_1234;
		weight_float = 32'h4148_0000;
		status_word = 32'h00A5_0C81;
		repeat (8) @(posedge clk);
		#10 rst_n = 1;
		step(1);
		chk("run", LED_OFF, network_run_indicator);
		t_states();
		t_errors();
		t_variant();
		t_data();
		t_links();
		t_reset();
		stop_test();
	end
	initial begin
		#1_000_000;
		fails++;
		stop_test();
	end
endmodule // tb_status_led_top
